// ---- verilog/trp_pkg.sv ----
// Constants and types shared by both ends of the temperature result link.
// Assumes a 10 MHz reference clock and a 100 kHz two-wire bus.
// Overview of operation
// - Keep 16-bit two's complement result register.
// - Left-justify result, zero unused low bits.
// - Sign sits in the top bit.
// - At 12 bits, bit 4 is 1/16 degree.
// - Reads never disturb background conversions.
// - Conversion during a read loads afterwards.
// - Master points at temperature before reading (a master read sends no pointer write; the device reads at its stored pointer).
// - Start plus read address matching strap bits.
// - Upper byte, master ACK, lower byte, NACK.
// - On master NACK, release the data line.
// - ACK after lower byte restarts with fresh upper.
// - NACK after upper byte skips lower byte.
// - Result clears at reset; master waits conversion (master only raises O_WARM after the wait; reads are not held back).
// - Shutdown still performs one conversion after reset.
// - Writes to result are refused with NACK.
// - Pointer selects temperature after reset.
package trp_pkg;
  localparam int TRP_RESULT_W = 16;
  localparam logic [3:0] TRP_ADDR_FIXED = 4'h9;
  localparam logic [7:0] TRP_PTR_TEMP = 8'h00;
  localparam logic [7:0] TRP_PTR_CFG = 8'h01;
  localparam logic [7:0] TRP_PTR_TLOW = 8'h02;
  localparam logic [7:0] TRP_PTR_THIGH = 8'h03;
  localparam logic [7:0] TRP_PTR_NVCFG = 8'h11;
  localparam logic [7:0] TRP_PTR_NVTLOW = 8'h12;
  localparam logic [7:0] TRP_PTR_NVTHIGH = 8'h13;
  localparam logic [15:0] TRP_RESULT_RESET = 16'h0000;
  localparam logic [15:0] TRP_READ_FILL = 16'hffff;
  localparam logic [7:0] TRP_BYTE_REL = 8'hff;
  localparam logic [1:0] TRP_RES_9 = 2'h0;
  localparam logic [1:0] TRP_RES_10 = 2'h1;
  localparam logic [1:0] TRP_RES_11 = 2'h2;
  localparam logic [15:0] TRP_MASK_9 = 16'hff80;
  localparam logic [15:0] TRP_MASK_10 = 16'hffc0;
  localparam logic [15:0] TRP_MASK_11 = 16'hffe0;
  localparam logic [15:0] TRP_MASK_12 = 16'hfff0;
  localparam logic [3:0] TRP_BITS_BYTE = 4'h8;
  localparam logic [3:0] TRP_CNT_ONE = 4'h1;
  localparam logic [1:0] TRP_Q0 = 2'h0;
  localparam logic [1:0] TRP_Q1 = 2'h1;
  localparam logic [1:0] TRP_Q2 = 2'h2;
  localparam logic [1:0] TRP_Q3 = 2'h3;
  localparam int TRP_CLK_HZ = 10_000_000;
  localparam int TRP_SCL_HZ = 100_000;
  localparam int TRP_QTR_CYC = TRP_CLK_HZ / (4 * TRP_SCL_HZ);
  localparam int TRP_CONV_TIME_MAX_US = 100_000;
  localparam int TRP_CONV_WAIT_CYC = TRP_CONV_TIME_MAX_US * (TRP_CLK_HZ / 1_000_000);
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} trp_dev_state_t;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} trp_rx_kind_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} trp_mst_state_t;
  typedef enum logic [2:0] {S_ADDR, S_PTR, S_WDATA, S_HI, S_LO} trp_stage_t;
endpackage

// ---- verilog/trp_i2c_if.sv ----
// Two-wire bus joining the result device and its bus master.
// Each party gives drive-low enables; the wired-AND level is resolved here.
`timescale 1ns/1ns
interface trp_i2c_if;
  logic scl;
  logic sda;
  logic m_scl;
  logic m_scl_oe_n;
  logic m_sda;
  logic m_sda_oe_n;
  logic d_sda;
  logic d_sda_oe_n;

  assign scl = ~(~m_scl_oe_n & ~m_scl);
  assign sda = ~((~m_sda_oe_n & ~m_sda) | (~d_sda_oe_n & ~d_sda));

  modport dev (input scl, input sda, output d_sda, output d_sda_oe_n);
  modport mst (input scl, input sda, output m_scl, output m_scl_oe_n,
               output m_sda, output m_sda_oe_n);
endinterface

// ---- verilog/trp_sensor_dev.sv ----
// Temperature result register with its two-wire read-out slave.
// Assumes bus levels synchronous to I_REF_CLK and a converter giving
// a 16-bit left-justified two's complement value with a done pulse.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module trp_sensor_dev (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic [2:0] I_STRAP,
  input wire logic [1:0] I_RES,
  input wire logic I_SHUTDOWN,
  input wire logic I_CONV_DONE,
  input wire logic [trp_pkg::TRP_RESULT_W-1:0] I_CONV_VALUE,
  output logic O_CONV_REQ,
  output logic [trp_pkg::TRP_RESULT_W-1:0] O_RESULT,
  output logic O_READ_BUSY,
  trp_i2c_if.dev BUS
);
  import trp_pkg::*;

  trp_dev_state_t state_reg, state_next;
  trp_rx_kind_t kind_reg, kind_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next;
  logic ack_reg, ack_next;
  logic hi_reg, hi_next;
  logic [15:0] snap_reg, snap_next;
  logic [7:0] ptr_reg, ptr_next;
  logic sda_oe_n_reg, sda_oe_n_next;
  logic scl_q_reg, sda_q_reg;
  logic busy_reg, busy_next;
  logic [15:0] temp_reg, temp_next;
  logic [15:0] pend_reg, pend_next;
  logic pend_v_reg, pend_v_next;
  logic oneshot_reg, oneshot_next;
  logic conv_req_reg, conv_req_next;
  logic reading;

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    case (res)
      TRP_RES_9: res_mask = TRP_MASK_9;
      TRP_RES_10: res_mask = TRP_MASK_10;
      TRP_RES_11: res_mask = TRP_MASK_11;
      default: res_mask = TRP_MASK_12;
    endcase
  endfunction

  function automatic logic ptr_ok(input logic [7:0] p);
    ptr_ok = (p == TRP_PTR_TEMP) || (p == TRP_PTR_CFG) || (p == TRP_PTR_TLOW) ||
             (p == TRP_PTR_THIGH) || (p == TRP_PTR_NVCFG) || (p == TRP_PTR_NVTLOW) ||
             (p == TRP_PTR_NVTHIGH);
  endfunction

  // --------------------------------------------------------------------
  // Two-wire slave
  // --------------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic send;
    logic [7:0] tx_byte;
    logic [15:0] fresh;
    rise = BUS.scl & ~scl_q_reg;
    fall = ~BUS.scl & scl_q_reg;
    send = 1'b0;
    tx_byte = TRP_BYTE_REL;
    fresh = (ptr_reg == TRP_PTR_TEMP) ? (pend_v_reg ? pend_reg : temp_reg) : TRP_READ_FILL;
    state_next = state_reg;
    kind_next = kind_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    ack_next = ack_reg;
    hi_next = hi_reg;
    snap_next = snap_reg;
    ptr_next = ptr_reg;
    sda_oe_n_next = sda_oe_n_reg;
    if (BUS.scl && scl_q_reg && sda_q_reg && !BUS.sda) begin
      state_next = ST_RX;
      kind_next = K_ADDR;
      cnt_next = '0;
      sda_oe_n_next = 1'b1;
    end else if (BUS.scl && scl_q_reg && !sda_q_reg && BUS.sda) begin
      state_next = ST_IDLE;
      sda_oe_n_next = 1'b1;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (rise) begin
            shift_next = {shift_reg[6:0], BUS.sda};
            cnt_next = cnt_reg + TRP_CNT_ONE;
          end else if (fall && cnt_reg == TRP_BITS_BYTE) begin
            state_next = ST_ACK;
            cnt_next = '0;
            ack_next = 1'b0;
            case (kind_reg)
              K_ADDR: begin
                if (shift_reg[7:1] == {TRP_ADDR_FIXED, I_STRAP}) begin
                  ack_next = 1'b1;
                  rd_next = shift_reg[0];
                end else begin
                  state_next = ST_IDLE;
                end
              end
              K_PTR: begin
                if (ptr_ok(shift_reg)) begin
                  ack_next = 1'b1;
                  ptr_next = shift_reg;
                end
              end
              default: ack_next = 1'b0;
            endcase
            sda_oe_n_next = ~ack_next;
          end
        end
        ST_ACK: begin
          if (rise) begin
            cnt_next = TRP_CNT_ONE;
          end else if (fall && cnt_reg == TRP_CNT_ONE) begin
            sda_oe_n_next = 1'b1;
            cnt_next = '0;
            if (rd_reg) begin
              snap_next = (ptr_reg == TRP_PTR_TEMP) ? temp_reg : TRP_READ_FILL;
              hi_next = 1'b1;
              tx_byte = snap_next[15:8];
              send = 1'b1;
            end else begin
              state_next = ST_RX;
              kind_next = (kind_reg == K_ADDR) ? K_PTR : K_DATA;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (cnt_reg == TRP_BITS_BYTE) begin
              sda_oe_n_next = 1'b1;
              state_next = ST_MACK;
              cnt_next = '0;
            end else begin
              sda_oe_n_next = shift_reg[7];
              shift_next = {shift_reg[6:0], 1'b1};
              cnt_next = cnt_reg + TRP_CNT_ONE;
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            ack_next = ~BUS.sda;
            cnt_next = TRP_CNT_ONE;
          end else if (fall && cnt_reg == TRP_CNT_ONE) begin
            if (ack_reg && hi_reg) begin
              hi_next = 1'b0;
              tx_byte = snap_reg[7:0];
              send = 1'b1;
            end else if (ack_reg) begin
              snap_next = fresh;
              hi_next = 1'b1;
              tx_byte = fresh[15:8];
              send = 1'b1;
            end else begin
              sda_oe_n_next = 1'b1;
              state_next = ST_IDLE;
            end
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    if (send) begin
      state_next = ST_TX;
      sda_oe_n_next = tx_byte[7];
      shift_next = {tx_byte[6:0], 1'b1};
      cnt_next = TRP_CNT_ONE;
    end
    busy_next = (state_next == ST_TX) || (state_next == ST_MACK) ||
                (state_next == ST_ACK && rd_next);
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_reg <= ST_IDLE;
      kind_reg <= K_ADDR;
      shift_reg <= '0;
      cnt_reg <= '0;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      hi_reg <= 1'b0;
      snap_reg <= TRP_RESULT_RESET;
      ptr_reg <= TRP_PTR_TEMP;
      sda_oe_n_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
      hi_reg <= hi_next;
      snap_reg <= snap_next;
      ptr_reg <= ptr_next;
      sda_oe_n_reg <= sda_oe_n_next;
      scl_q_reg <= BUS.scl;
      sda_q_reg <= BUS.sda;
      busy_reg <= busy_next;
    end
  end

  // --------------------------------------------------------------------
  // Result register and conversion requests
  // --------------------------------------------------------------------
  assign reading = busy_reg;

  always_comb begin
    logic [15:0] fmt;
    fmt = I_CONV_VALUE & res_mask(I_RES);
    temp_next = temp_reg;
    pend_next = pend_reg;
    pend_v_next = pend_v_reg;
    if (I_CONV_DONE && reading) begin
      pend_next = fmt;
      pend_v_next = 1'b1;
    end else if (I_CONV_DONE) begin
      temp_next = fmt;
      pend_v_next = 1'b0;
    end else if (pend_v_reg && !reading) begin
      temp_next = pend_reg;
      pend_v_next = 1'b0;
    end
    oneshot_next = oneshot_reg & ~I_CONV_DONE;
    conv_req_next = ~I_SHUTDOWN | oneshot_next;
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      temp_reg <= TRP_RESULT_RESET;
      pend_reg <= TRP_RESULT_RESET;
      pend_v_reg <= 1'b0;
      oneshot_reg <= 1'b1;
      conv_req_reg <= 1'b0;
    end else begin
      temp_reg <= temp_next;
      pend_reg <= pend_next;
      pend_v_reg <= pend_v_next;
      oneshot_reg <= oneshot_next;
      conv_req_reg <= conv_req_next;
    end
  end

  assign O_CONV_REQ = conv_req_reg;
  assign O_RESULT = temp_reg;
  assign O_READ_BUSY = busy_reg;
  assign BUS.d_sda = 1'b0;
  assign BUS.d_sda_oe_n = sda_oe_n_reg;
endmodule

// ---- verilog/trp_bus_master.sv ----
// Two-wire bus master that sets the pointer and reads the result.
// Assumes a device that never stretches the clock.
`timescale 1ns/1ns
module trp_bus_master #(
  parameter int QTR_CYC = trp_pkg::TRP_QTR_CYC,
  parameter int CONV_WAIT_CYC = trp_pkg::TRP_CONV_WAIT_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_RD_REQ,
  input wire logic I_PTR_REQ,
  input wire logic [2:0] I_ADDR,
  input wire logic I_LEN16,
  input wire logic I_LOOP,
  input wire logic [7:0] I_PTR_VAL,
  input wire logic I_WR_EN,
  input wire logic [7:0] I_WR_DATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_NACK,
  output logic O_WARM,
  output logic [trp_pkg::TRP_RESULT_W-1:0] O_DATA,
  trp_i2c_if.mst BUS
);
  import trp_pkg::*;

  if (QTR_CYC < 2 || QTR_CYC > 65535 || CONV_WAIT_CYC < 1 || CONV_WAIT_CYC > 16777215) begin
    $error("trp_bus_master parameter out of range");
  end

  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);
  localparam logic [23:0] WAIT_LAST = 24'(CONV_WAIT_CYC - 1);

  trp_mst_state_t state_reg, state_next;
  trp_stage_t stage_reg, stage_next;
  logic [15:0] qcnt_reg, qcnt_next;
  logic [1:0] qph_reg, qph_next;
  logic [3:0] bit_reg, bit_next;
  logic [8:0] tx_reg, tx_next, rx_reg, rx_next;
  logic rd_reg, rd_next, len_reg, len_next, loop_reg, loop_next;
  logic wen_reg, wen_next;
  logic [7:0] ptr_reg, ptr_next, wdata_reg, wdata_next;
  logic [15:0] data_reg, data_next;
  logic done_reg, done_next, nack_reg, nack_next, busy_reg, busy_next;
  logic scl_oe_n_reg, scl_oe_n_next, sda_oe_n_reg, sda_oe_n_next;
  logic [23:0] wcnt_reg, wcnt_next;
  logic warm_reg, warm_next;

  // --------------------------------------------------------------------
  // Transfer sequencer
  // --------------------------------------------------------------------
  always_comb begin
    logic tick;
    tick = (qcnt_reg == QTR_LAST);
    state_next = state_reg;
    stage_next = stage_reg;
    qcnt_next = tick ? '0 : qcnt_reg + 16'h0001;
    qph_next = tick ? qph_reg + 2'h1 : qph_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rd_next = rd_reg;
    len_next = len_reg;
    loop_next = loop_reg;
    wen_next = wen_reg;
    ptr_next = ptr_reg;
    wdata_next = wdata_reg;
    data_next = data_reg;
    done_next = 1'b0;
    nack_next = nack_reg;
    busy_next = busy_reg;
    scl_oe_n_next = scl_oe_n_reg;
    sda_oe_n_next = sda_oe_n_reg;
    case (state_reg)
      M_IDLE: begin
        qcnt_next = '0;
        qph_next = TRP_Q0;
        if (I_RD_REQ || I_PTR_REQ) begin
          state_next = M_START;
          stage_next = S_ADDR;
          rd_next = I_RD_REQ;
          len_next = I_LEN16;
          loop_next = I_LOOP & I_LEN16;
          wen_next = I_WR_EN;
          ptr_next = I_PTR_VAL;
          wdata_next = I_WR_DATA;
          tx_next = {TRP_ADDR_FIXED, I_ADDR, I_RD_REQ, 1'b1};
          nack_next = 1'b0;
          busy_next = 1'b1;
        end
      end
      M_START: begin
        if (tick) begin
          case (qph_reg)
            TRP_Q0: sda_oe_n_next = 1'b1;
            TRP_Q1: sda_oe_n_next = 1'b0;
            TRP_Q2: scl_oe_n_next = 1'b0;
            default: begin
              state_next = M_BYTE;
              bit_next = '0;
            end
          endcase
        end
      end
      M_BYTE: begin
        if (tick) begin
          case (qph_reg)
            TRP_Q0: sda_oe_n_next = tx_reg[8];
            TRP_Q1: scl_oe_n_next = 1'b1;
            TRP_Q2: rx_next = {rx_reg[7:0], BUS.sda};
            default: begin
              scl_oe_n_next = 1'b0;
              tx_next = {tx_reg[7:0], 1'b1};
              bit_next = bit_reg + TRP_CNT_ONE;
              if (bit_reg == TRP_BITS_BYTE) begin
                bit_next = '0;
                state_next = M_STOP;
                case (stage_reg)
                  S_ADDR: begin
                    if (rx_reg[0]) begin
                      nack_next = 1'b1;
                    end else if (rd_reg) begin
                      state_next = M_BYTE;
                      stage_next = S_HI;
                      tx_next = {TRP_BYTE_REL, ~len_reg};
                    end else begin
                      state_next = M_BYTE;
                      stage_next = S_PTR;
                      tx_next = {ptr_reg, 1'b1};
                    end
                  end
                  S_PTR: begin
                    if (rx_reg[0]) begin
                      nack_next = 1'b1;
                    end else if (wen_reg) begin
                      state_next = M_BYTE;
                      stage_next = S_WDATA;
                      tx_next = {wdata_reg, 1'b1};
                    end
                  end
                  S_WDATA: nack_next = rx_reg[0];
                  S_HI: begin
                    data_next = {rx_reg[8:1], 8'h00};
                    if (len_reg) begin
                      state_next = M_BYTE;
                      stage_next = S_LO;
                      tx_next = {TRP_BYTE_REL, ~loop_reg};
                    end
                  end
                  default: begin
                    data_next = {data_reg[15:8], rx_reg[8:1]};
                    if (loop_reg) begin
                      loop_next = 1'b0;
                      state_next = M_BYTE;
                      stage_next = S_HI;
                      tx_next = {TRP_BYTE_REL, 1'b0};
                    end
                  end
                endcase
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          case (qph_reg)
            TRP_Q0: sda_oe_n_next = 1'b0;
            TRP_Q1: scl_oe_n_next = 1'b1;
            TRP_Q2: sda_oe_n_next = 1'b1;
            default: begin
              state_next = M_IDLE;
              busy_next = 1'b0;
              done_next = 1'b1;
            end
          endcase
        end
      end
      default: state_next = M_IDLE;
    endcase
    wcnt_next = warm_reg ? wcnt_reg : wcnt_reg + 24'h000001;
    warm_next = warm_reg | (wcnt_reg == WAIT_LAST);
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_reg <= M_IDLE;
      stage_reg <= S_ADDR;
      qcnt_reg <= '0;
      qph_reg <= TRP_Q0;
      bit_reg <= '0;
      tx_reg <= '1;
      rx_reg <= '0;
      rd_reg <= 1'b0;
      len_reg <= 1'b0;
      loop_reg <= 1'b0;
      wen_reg <= 1'b0;
      ptr_reg <= TRP_PTR_TEMP;
      wdata_reg <= '0;
      data_reg <= TRP_RESULT_RESET;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      busy_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      wcnt_reg <= '0;
      warm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      stage_reg <= stage_next;
      qcnt_reg <= qcnt_next;
      qph_reg <= qph_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rd_reg <= rd_next;
      len_reg <= len_next;
      loop_reg <= loop_next;
      wen_reg <= wen_next;
      ptr_reg <= ptr_next;
      wdata_reg <= wdata_next;
      data_reg <= data_next;
      done_reg <= done_next;
      nack_reg <= nack_next;
      busy_reg <= busy_next;
      scl_oe_n_reg <= scl_oe_n_next;
      sda_oe_n_reg <= sda_oe_n_next;
      wcnt_reg <= wcnt_next;
      warm_reg <= warm_next;
    end
  end

  assign O_BUSY = busy_reg;
  assign O_DONE = done_reg;
  assign O_NACK = nack_reg;
  assign O_WARM = warm_reg;
  assign O_DATA = data_reg;
  assign BUS.m_scl = 1'b0;
  assign BUS.m_sda = 1'b0;
  assign BUS.m_scl_oe_n = scl_oe_n_reg;
  assign BUS.m_sda_oe_n = sda_oe_n_reg;
endmodule

// ---- tb/trp_link_monitor.sv ----
// Concurrent checks on the two-wire link and on the result register.
// Assumes link levels and device ports of the one clock domain as inputs.
`timescale 1ns/1ns
module trp_link_monitor #(
  parameter int QTR_CYC = trp_pkg::TRP_QTR_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic [1:0] I_RES,
  input wire logic I_SHUTDOWN,
  input wire logic I_CONV_DONE,
  input wire logic [trp_pkg::TRP_RESULT_W-1:0] I_CONV_VALUE,
  input wire logic O_CONV_REQ,
  input wire logic [trp_pkg::TRP_RESULT_W-1:0] O_RESULT,
  input wire logic O_READ_BUSY,
  input wire logic scl,
  input wire logic d_sda_oe_n
);
  import trp_pkg::*;
  // ----------
  // Properties
  // ----------
  // A looping read spans four bytes and their acknowledge bits.
  localparam int BUSY_MAX = 160 * QTR_CYC;
  logic [15:0] load_val;
  assign load_val = I_CONV_VALUE & (16'hffff << (3'h7 - {1'b0, I_RES}));
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RESET);
  sequence s_released;
    d_sda_oe_n [*4];
  endsequence
  property p_load;
    I_CONV_DONE && !O_READ_BUSY |=> O_RESULT == $past(load_val);
  endproperty
  result_hold_a: assert property (!$stable(O_RESULT) |-> !$past(O_READ_BUSY))
    else $error("result changed during a read");
  result_load_a: assert property (p_load)
    else $error("result not loaded with the masked value");
  sda_change_a: assert property (!$stable(d_sda_oe_n) |-> !scl)
    else $error("device changed the data line while the clock was high");
  nack_release_a: assert property ($fell(O_READ_BUSY) |-> s_released)
    else $error("data line not released after the read ended");
  busy_span_a: assert property ($rose(O_READ_BUSY) |-> ##[1:BUSY_MAX] !O_READ_BUSY)
    else $error("read never ended");
  conv_start_a: assert property ($fell(I_RESET) |=> O_CONV_REQ)
    else $error("no conversion requested after reset");
  one_shot_a: assert property (I_CONV_DONE && I_SHUTDOWN |-> ##[1:2] !O_CONV_REQ)
    else $error("conversion request kept in shutdown");
  run_mode_a: assert property (!I_SHUTDOWN [*2] |=> O_CONV_REQ)
    else $error("conversions stopped while running");
endmodule

// ---- tb/temperature_result_readout_test.sv ----
// Bench joining the result device and its bus master on one two-wire link.
// Assumes a 10 MHz clock with shortened bus quarters and warm-up count.
`timescale 1ns/1ns
`define CHECK(w, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected %s: expected %h seen %h", w, e, g); \
  end \
end
module temperature_result_readout_test;
  import trp_pkg::*;
  localparam int QTR = 3;
  localparam logic [2:0] STRAP = 3'h2;
  logic clk, rst, rd_req, ptr_req, len16, loop_en, wr_en, conv_done, shutdown;
  logic busy, done, nack, warm, conv_req, rd_busy;
  logic [1:0] res;
  logic [2:0] addr;
  logic [7:0] ptr_val;
  logic [15:0] conv_val, data, result, old, nv;
  logic [27:0] wire_sh;
  int n_mismatch, n_tests, wire_bits, k;
  // ------------
  // Link and ends
  // ------------
  trp_i2c_if bus ();
  trp_sensor_dev i_trp_sensor_dev (
    .I_REF_CLK(clk), .I_RESET(rst), .I_STRAP(STRAP), .I_RES(res), .I_SHUTDOWN(shutdown),
    .I_CONV_DONE(conv_done), .I_CONV_VALUE(conv_val), .O_CONV_REQ(conv_req),
    .O_RESULT(result), .O_READ_BUSY(rd_busy), .BUS(bus)
  );
  trp_bus_master #(.QTR_CYC(QTR), .CONV_WAIT_CYC(50)) i_trp_bus_master (
    .I_REF_CLK(clk), .I_RESET(rst), .I_RD_REQ(rd_req), .I_PTR_REQ(ptr_req), .I_ADDR(addr),
    .I_LEN16(len16), .I_LOOP(loop_en), .I_PTR_VAL(ptr_val), .I_WR_EN(wr_en),
    .I_WR_DATA(8'h55), .O_BUSY(busy), .O_DONE(done), .O_NACK(nack), .O_WARM(warm),
    .O_DATA(data), .BUS(bus)
  );
  trp_link_monitor #(.QTR_CYC(QTR)) i_trp_link_monitor (
    .I_REF_CLK(clk), .I_RESET(rst), .I_RES(res), .I_SHUTDOWN(shutdown),
    .I_CONV_DONE(conv_done), .I_CONV_VALUE(conv_val), .O_CONV_REQ(conv_req),
    .O_RESULT(result), .O_READ_BUSY(rd_busy), .scl(bus.scl), .d_sda_oe_n(bus.d_sda_oe_n)
  );
  // -----
  // Tasks
  // -----
  // Every bit on the wire is shifted in at the clock rise; a start clears the count.
  always @(negedge bus.sda) if (bus.scl === 1'b1) wire_bits = 0;
  always @(posedge bus.scl) begin
    wire_sh = {wire_sh[26:0], bus.sda};
    wire_bits++;
  end
  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic run(input logic rd, input logic [2:0] a, input logic l16, input logic lp,
                     input logic [7:0] p, input logic we, input logic en, input logic [15:0] e);
    logic [15:0] wd;
    @(posedge clk);
    rd_req <= rd;
    ptr_req <= !rd;
    addr <= a;
    len16 <= l16;
    loop_en <= lp;
    ptr_val <= p;
    wr_en <= we;
    @(posedge clk);
    rd_req <= 1'b0;
    ptr_req <= 1'b0;
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
    `CHECK("done", 1'b1, done)
    `CHECK("nack", en, nack)
    `CHECK("busy", 1'b0, busy)
    wd = l16 ? {wire_sh[18:11], wire_sh[9:2]} : {wire_sh[9:2], 8'h00};
    if (!lp) begin
      `CHECK("wire address", {4'h9, a, rd}, wire_sh[wire_bits-1 -: 8])
      `CHECK("wire address ack", a != STRAP, wire_sh[wire_bits-9])
    end
    if (rd && !en) begin
      `CHECK("data", e, data)
      if (!lp) begin
        `CHECK("wire data", e, wd)
        `CHECK("wire final nack", 1'b1, wire_sh[1])
      end
    end
  endtask
  task automatic conv(input logic [15:0] v, input logic [1:0] r, input logic sd);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_val <= v;
    res <= r;
    shutdown <= sd;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // -----
  // Tests
  // -----
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rst, shutdown} = 2'b11;
    {rd_req, ptr_req, len16, loop_en, wr_en, conv_done} = 6'h00;
    res = 2'h3;
    addr = STRAP;
    ptr_val = 8'h00;
    conv_val = 16'h0000;
    wire_sh = 28'h0000000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHECK("reset result", 16'h0000, result)
    `CHECK("early warm", 1'b0, warm)
    @(negedge clk);
    `CHECK("one-shot request", 1'b1, conv_req)
    run(1'b1, STRAP, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 16'h0000);
    conv(16'h0010, 2'h3, 1'b1);
    `CHECK("shutdown request", 1'b0, conv_req)
    `CHECK("one step", 16'h0010, result)
    for (int r = 0; r < 4; r++) begin
      conv(16'hf5ef, r[1:0], 1'b0);
      old = 16'hf5ef & (16'hffff << (7 - r));
      `CHECK("masked result", old, result)
      run(1'b1, STRAP, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, old);
      run(1'b1, STRAP, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, {old[15:8], 8'h00});
    end
    for (int lp = 0; lp < 2; lp++) begin
      old = result;
      nv = lp ? 16'he7c0 : 16'h1940;
      fork
        run(1'b1, STRAP, 1'b1, lp[0], 8'h00, 1'b0, 1'b0, lp ? nv : old);
        begin
          for (k = 0; k < 2000 && rd_busy !== 1'b1; k++) @(negedge clk);
          conv(nv, 2'h3, 1'b0);
          `CHECK("result during read", old, result)
        end
      join
      `CHECK("result after read", nv, result)
      `CHECK("conversions run", 1'b1, conv_req)
    end
    run(1'b1, 3'h5, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 16'h0000);
    run(1'b0, STRAP, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 16'h0000);
    run(1'b0, STRAP, 1'b0, 1'b0, 8'h05, 1'b0, 1'b1, 16'h0000);
    run(1'b0, STRAP, 1'b0, 1'b0, 8'h00, 1'b1, 1'b1, 16'h0000);
    run(1'b1, STRAP, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 16'he7c0);
    `CHECK("warm", 1'b1, warm)
    stop_test();
  end
endmodule
